//--- ulpi_fc_pkg.sv
package ulpi_fc_pkg;

  localparam logic [5:0] ADDR_FC = 6'h04;
  localparam logic [5:0] ADDR_FC_SET = 6'h05;
  localparam logic [5:0] ADDR_FC_CLR = 6'h06;

  localparam logic [1:0] CMD_REG_WRITE = 2'h2;
  localparam logic [1:0] CMD_REG_READ = 2'h3;
  localparam int CMD_MSB = 7;
  localparam int CMD_LSB = 6;
  localparam int ADDR_MSB = 5;

  localparam int FC_LOW_POWER_N_BIT = 6;
  localparam int FC_XCVR_RESET_BIT = 5;
  localparam int FC_STYLE_MSB = 4;
  localparam int FC_STYLE_LSB = 3;
  localparam int FC_TERM_BIT = 2;
  localparam int FC_SPEED_MSB = 1;
  localparam int FC_SPEED_LSB = 0;

  localparam logic [7:0] FC_RESET_VALUE = 8'h41;
  localparam logic [7:0] FC_WRITE_MASK = 8'h7f;
  localparam logic [7:0] FC_READ_MASK = 8'h5f;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  localparam int CORE_RESET_CYCLES_DEFAULT = 16;

  localparam int RXCMD_LINE_LSB = 0;
  localparam int RXCMD_VBUS_LSB = 2;

  typedef enum logic [1:0] {
    SPEED_HS = 2'h0,
    SPEED_FS = 2'h1,
    SPEED_LS = 2'h2,
    SPEED_FS_FOR_LS = 2'h3
  } speed_t;

  typedef enum logic [1:0] {
    STYLE_NORMAL = 2'h0,
    STYLE_NON_DRIVING = 2'h1,
    STYLE_NO_STUFF_NRZI = 2'h2,
    STYLE_RESERVED = 2'h3
  } style_t;

  typedef enum logic [1:0] {
    WR_PLAIN = 2'h0,
    WR_SET = 2'h1,
    WR_CLEAR = 2'h2
  } wr_kind_t;

  localparam int CTL_CORE_POWER = 0;
  localparam int CTL_HS_XCVR = 1;
  localparam int CTL_FS_XCVR = 2;
  localparam int CTL_LS_XCVR = 3;
  localparam int CTL_FS_PREAMBLE = 4;
  localparam int CTL_TX_DRIVE = 5;
  localparam int CTL_BITSTUFF_NRZI = 6;
  localparam int CTL_STYLE_RSVD = 7;
  localparam int CTL_PULLUP_DP = 8;
  localparam int CTL_PULLUP_DM = 9;
  localparam int CTL_HS_TERM = 10;
  localparam int CTL_W = 11;

  function automatic logic [7:0] fc_readback(input logic [7:0] value);
    fc_readback = value & FC_READ_MASK;
  endfunction

  function automatic logic [CTL_W-1:0] ctl_decode(input logic [7:0] fc,
                                                  input logic dp_pd, input logic dm_pd);
    logic [CTL_W-1:0] c;
    logic awake;
    logic periph;
    logic [1:0] spd;
    logic [1:0] sty;
    c = '0;
    awake = fc[FC_LOW_POWER_N_BIT];
    periph = !(dp_pd || dm_pd);
    spd = fc[FC_SPEED_MSB:FC_SPEED_LSB];
    sty = fc[FC_STYLE_MSB:FC_STYLE_LSB];
    c[CTL_CORE_POWER] = awake;
    c[CTL_HS_XCVR] = awake && (spd == SPEED_HS);
    c[CTL_FS_XCVR] = awake && (spd == SPEED_FS || spd == SPEED_FS_FOR_LS);
    c[CTL_LS_XCVR] = awake && (spd == SPEED_LS);
    c[CTL_FS_PREAMBLE] = (spd == SPEED_FS_FOR_LS);
    c[CTL_TX_DRIVE] = (sty != STYLE_NON_DRIVING);
    c[CTL_BITSTUFF_NRZI] = (sty != STYLE_NO_STUFF_NRZI);
    c[CTL_STYLE_RSVD] = (sty == STYLE_RESERVED);
    c[CTL_PULLUP_DP] = periph && fc[FC_TERM_BIT] && (spd != SPEED_LS);
    c[CTL_PULLUP_DM] = periph && fc[FC_TERM_BIT] && (spd == SPEED_LS);
    c[CTL_HS_TERM] = !fc[FC_TERM_BIT] && (spd == SPEED_HS) && (sty != STYLE_NON_DRIVING);
    ctl_decode = c;
  endfunction

endpackage

//--- cycle_timer.sv
`timescale 1ns/1ps
`default_nettype none
module cycle_timer #(
  parameter int CYCLES = 16
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic start,
  output logic done
);
  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LOAD = W'(CYCLES - 1);

  logic [W-1:0] count_reg;
  logic run_reg;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= '0;
      run_reg <= 1'b0;
    end else if (start) begin
      count_reg <= LOAD;
      run_reg <= 1'b1;
    end else if (run_reg) begin
      if (count_reg == '0) begin
        run_reg <= 1'b0;
      end else begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

  assign done = run_reg && (count_reg == '0);
endmodule
`default_nettype wire

//--- func_ctrl_merge.sv
`timescale 1ns/1ps
`default_nettype none
module func_ctrl_merge
  import ulpi_fc_pkg::*;
(
  input wire logic [7:0] current,
  input wire logic [7:0] wdata,
  input wire logic [1:0] kind,
  output logic [7:0] merged
);
  // Bit 7 is masked on every path so it can never become one
  always_comb begin
    unique case (kind)
      WR_PLAIN: merged = wdata & FC_WRITE_MASK;
      WR_SET: merged = (current | wdata) & FC_WRITE_MASK;
      WR_CLEAR: merged = current & ~wdata & FC_WRITE_MASK;
      default: merged = current & FC_WRITE_MASK;
    endcase
  end
endmodule
`default_nettype wire

//--- ulpi_func_ctrl.sv
// Summary of operation
// - Suspend bit low powers down all but FS receiver, comparators and interface pins.
// - Leaving low-power mode sets the suspend bit again by hardware.
// - Transceiver reset hits only the core; interface and registers stay.
// - Reset bit set: raise DIR, reset core, then drop DIR, clear bit.
// - After that DIR drop, raise DIR again and send an RX command.
// - Reset bit always reads back as zero.
// - Bits 4:3 pick transmit style: normal, non-driving, no stuffing/NRZI.
// - Transmit style 3 is reserved and behaves as normal.
// - Bit 2 controls pull-up and HS terminations, per speed, style, pulldowns.
// - Bits 1:0 pick HS, FS or LS transceiver.
// - Speed code 3 sends LS packets on FS transceiver with preamble.
// - Reset value: suspend bit one, speed FS, all else zero.
// - Offset 0x04 reads and writes the function settings.
// - Offset 0x05 reads the register; written ones set bits.
// - Offset 0x06 reads the register; written ones clear bits.
`timescale 1ns/1ps
`default_nettype none
module ulpi_func_ctrl
  import ulpi_fc_pkg::*;
#(
  parameter int CORE_RESET_CYCLES = CORE_RESET_CYCLES_DEFAULT
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [7:0] ulpi_data_in,
  output logic [7:0] ulpi_data_out,
  output logic ulpi_data_oe,
  output logic ulpi_dir,
  output logic ulpi_nxt,
  input wire logic ulpi_stp,
  input wire logic low_power_exit,
  input wire logic [1:0] line_state,
  input wire logic [1:0] vbus_state,
  input wire logic plus_line_pulldown,
  input wire logic minus_line_pulldown,
  output logic low_power_n,
  output logic [1:0] speed_select,
  output logic [1:0] transmit_style,
  output logic termination_select,
  output logic core_reset,
  output logic core_power_en,
  output logic hs_xcvr_en,
  output logic fs_xcvr_en,
  output logic ls_xcvr_en,
  output logic fs_preamble_en,
  output logic tx_drive_en,
  output logic bitstuff_nrzi_en,
  output logic style_reserved,
  output logic pullup_dp_en,
  output logic pullup_dm_en,
  output logic hs_term_en
);
  localparam logic [CTL_W-1:0] CTL_RESET = ctl_decode(FC_RESET_VALUE, 1'b0, 1'b0);

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_WR_CMD = 4'h1,
    ST_WR_DATA = 4'h2,
    ST_WR_STP = 4'h3,
    ST_RD_CMD = 4'h4,
    ST_RD_TURN = 4'h5,
    ST_RD_DATA = 4'h6,
    ST_RD_END = 4'h7,
    ST_XR_HOLD = 4'h8,
    ST_XR_GAP = 4'h9,
    ST_XR_TURN = 4'ha,
    ST_XR_RXCMD = 4'hb
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic [7:0] fc_reg;
  logic [7:0] fc_next;
  logic [7:0] merged;
  logic [5:0] addr_reg;
  logic [7:0] wdata_reg;
  logic [7:0] data_out_reg;
  logic core_reset_reg;
  logic [CTL_W-1:0] ctl_reg;
  logic timer_start;
  logic timer_done;
  logic addr_mapped;
  logic [1:0] wr_kind;
  logic commit;

  cycle_timer #(
    .CYCLES(CORE_RESET_CYCLES)
  ) u_core_timer (
    .mclk(mclk),
    .arst_n(arst_n),
    .start(timer_start),
    .done(timer_done)
  );

  func_ctrl_merge u_merge (
    .current(fc_reg),
    .wdata(wdata_reg),
    .kind(wr_kind),
    .merged(merged)
  );

  // Only the three function-control offsets are decoded here
  always_comb begin
    addr_mapped = 1'b1;
    wr_kind = WR_PLAIN;
    unique case (addr_reg)
      ADDR_FC: wr_kind = WR_PLAIN;
      ADDR_FC_SET: wr_kind = WR_SET;
      ADDR_FC_CLR: wr_kind = WR_CLEAR;
      default: addr_mapped = 1'b0;
    endcase
  end

  assign commit = (state_reg == ST_WR_STP) && ulpi_stp && addr_mapped;
  assign timer_start = (state_reg == ST_IDLE) && fc_reg[FC_XCVR_RESET_BIT];

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        // A pending core reset takes the bus before any new command
        if (fc_reg[FC_XCVR_RESET_BIT]) begin
          state_next = ST_XR_HOLD;
        end else if (ulpi_data_in[CMD_MSB:CMD_LSB] == CMD_REG_WRITE) begin
          state_next = ST_WR_CMD;
        end else if (ulpi_data_in[CMD_MSB:CMD_LSB] == CMD_REG_READ) begin
          state_next = ST_RD_CMD;
        end
      end
      ST_WR_CMD: state_next = ST_WR_DATA;
      ST_WR_DATA: state_next = ST_WR_STP;
      ST_WR_STP: begin
        if (ulpi_stp) begin
          state_next = ST_IDLE;
        end
      end
      ST_RD_CMD: state_next = ST_RD_TURN;
      ST_RD_TURN: state_next = ST_RD_DATA;
      ST_RD_DATA: state_next = ST_RD_END;
      ST_RD_END: state_next = ST_IDLE;
      ST_XR_HOLD: begin
        if (timer_done) begin
          state_next = ST_XR_GAP;
        end
      end
      ST_XR_GAP: state_next = ST_XR_TURN;
      ST_XR_TURN: state_next = ST_XR_RXCMD;
      ST_XR_RXCMD: state_next = ST_RD_END;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      addr_reg <= '0;
      wdata_reg <= '0;
    end else begin
      if (state_reg == ST_IDLE) begin
        addr_reg <= ulpi_data_in[ADDR_MSB:0];
      end
      if (state_reg == ST_WR_DATA) begin
        wdata_reg <= ulpi_data_in;
      end
    end
  end

  // Register contents; a core reset never touches them
  always_comb begin
    fc_next = fc_reg;
    if (commit) begin
      fc_next = merged;
    end
    if (state_reg == ST_XR_GAP) begin
      fc_next[FC_XCVR_RESET_BIT] = 1'b0;
    end
    // Hardware set is applied last so it wins over a clearing write
    if (low_power_exit) begin
      fc_next[FC_LOW_POWER_N_BIT] = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      fc_reg <= FC_RESET_VALUE;
    end else begin
      fc_reg <= fc_next;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      data_out_reg <= '0;
    end else if (state_reg == ST_RD_TURN) begin
      data_out_reg <= addr_mapped ? fc_readback(fc_reg) : UNMAPPED_READ;
    end else if (state_reg == ST_XR_TURN) begin
      data_out_reg <= '0;
      data_out_reg[RXCMD_LINE_LSB +: 2] <= line_state;
      data_out_reg[RXCMD_VBUS_LSB +: 2] <= vbus_state;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      core_reset_reg <= 1'b0;
    end else begin
      core_reset_reg <= (state_next == ST_XR_HOLD);
    end
  end

  // Registered so the analog controls never glitch on a bus write
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_reg <= CTL_RESET;
    end else begin
      ctl_reg <= ctl_decode(fc_reg, plus_line_pulldown, minus_line_pulldown);
    end
  end

  assign ulpi_dir = (state_reg == ST_RD_TURN) || (state_reg == ST_RD_DATA) ||
                    (state_reg == ST_XR_HOLD) || (state_reg == ST_XR_TURN) ||
                    (state_reg == ST_XR_RXCMD);
  assign ulpi_nxt = (state_reg == ST_WR_CMD) || (state_reg == ST_WR_DATA) ||
                    (state_reg == ST_RD_CMD);
  assign ulpi_data_oe = (state_reg == ST_RD_DATA) || (state_reg == ST_XR_RXCMD);
  assign ulpi_data_out = data_out_reg;

  assign low_power_n = fc_reg[FC_LOW_POWER_N_BIT];
  assign speed_select = fc_reg[FC_SPEED_MSB:FC_SPEED_LSB];
  assign transmit_style = fc_reg[FC_STYLE_MSB:FC_STYLE_LSB];
  assign termination_select = fc_reg[FC_TERM_BIT];
  assign core_reset = core_reset_reg;
  assign core_power_en = ctl_reg[CTL_CORE_POWER];
  assign hs_xcvr_en = ctl_reg[CTL_HS_XCVR];
  assign fs_xcvr_en = ctl_reg[CTL_FS_XCVR];
  assign ls_xcvr_en = ctl_reg[CTL_LS_XCVR];
  assign fs_preamble_en = ctl_reg[CTL_FS_PREAMBLE];
  assign tx_drive_en = ctl_reg[CTL_TX_DRIVE];
  assign bitstuff_nrzi_en = ctl_reg[CTL_BITSTUFF_NRZI];
  assign style_reserved = ctl_reg[CTL_STYLE_RSVD];
  assign pullup_dp_en = ctl_reg[CTL_PULLUP_DP];
  assign pullup_dm_en = ctl_reg[CTL_PULLUP_DM];
  assign hs_term_en = ctl_reg[CTL_HS_TERM];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  sequence seq_dir_gap;
    !ulpi_dir && !core_reset_reg;
  endsequence

  sequence seq_rxcmd_out;
    ulpi_dir && !ulpi_data_oe ##1 ulpi_dir && ulpi_data_oe ##1 !ulpi_dir;
  endsequence

  a_reset_end_rxcmd: assert property (
    $fell(core_reset_reg) |-> seq_dir_gap ##1 seq_rxcmd_out)
    else $error("no RX command after core reset");

  a_core_reset_dir: assert property (core_reset_reg |-> ulpi_dir)
    else $error("core reset without DIR");

  a_reset_bit_clear: assert property ($fell(core_reset_reg) |=> !fc_reg[FC_XCVR_RESET_BIT])
    else $error("reset bit not cleared");

  a_reset_keeps_regs: assert property (
    core_reset_reg && !low_power_exit |=> $stable(fc_reg[FC_STYLE_MSB:0]))
    else $error("core reset changed registers");

  a_reset_reads_zero: assert property (ulpi_data_oe && !core_reset_reg &&
    $past(state_reg) == ST_RD_TURN |-> !ulpi_data_out[FC_XCVR_RESET_BIT])
    else $error("reset bit read as one");

  a_bit7_zero: assert property (!fc_reg[7] && !(state_reg == ST_RD_DATA && ulpi_data_out[7]))
    else $error("bit 7 not zero");

  a_lp_exit_sets: assert property (low_power_exit |=> fc_reg[FC_LOW_POWER_N_BIT])
    else $error("suspend bit not restored");

  a_lp_powerdown: assert property (!fc_reg[FC_LOW_POWER_N_BIT] |=>
    !core_power_en && !hs_xcvr_en && !fs_xcvr_en && !ls_xcvr_en)
    else $error("blocks powered in low-power mode");

  a_set_alias: assert property (commit && wr_kind == WR_SET && !low_power_exit |=>
    fc_reg == (($past(fc_reg) | $past(wdata_reg)) & FC_WRITE_MASK))
    else $error("set alias wrong");

  a_clear_alias: assert property (commit && wr_kind == WR_CLEAR |=>
    fc_reg[5:0] == ($past(fc_reg[5:0]) & ~$past(wdata_reg[5:0])))
    else $error("clear alias wrong");

  a_speed_hs: assert property (fc_reg[FC_LOW_POWER_N_BIT] && speed_select == SPEED_HS |=>
    hs_xcvr_en && !fs_xcvr_en && !ls_xcvr_en)
    else $error("HS select wrong");

  a_fs_preamble: assert property (
    fc_reg[FC_LOW_POWER_N_BIT] && speed_select == SPEED_FS_FOR_LS |=> fs_xcvr_en && fs_preamble_en)
    else $error("preamble mode wrong");

  a_style_reserved: assert property (transmit_style == STYLE_RESERVED |=>
    style_reserved && tx_drive_en && bitstuff_nrzi_en)
    else $error("reserved style not normal");

  sequence seq_write_cmd;
    state_reg == ST_IDLE && !fc_reg[FC_XCVR_RESET_BIT] &&
      ulpi_data_in[CMD_MSB:CMD_LSB] == CMD_REG_WRITE;
  endsequence

  sequence seq_read_cmd;
    state_reg == ST_IDLE && !fc_reg[FC_XCVR_RESET_BIT] &&
      ulpi_data_in[CMD_MSB:CMD_LSB] == CMD_REG_READ && ulpi_data_in[ADDR_MSB:0] == ADDR_FC;
  endsequence

  sequence seq_read_reply;
    ulpi_nxt && !ulpi_dir ##1 ulpi_dir && !ulpi_data_oe ##1 ulpi_dir && ulpi_data_oe;
  endsequence

  a_write_nxt: assert property (seq_write_cmd |=> ulpi_nxt && !ulpi_dir ##1 ulpi_nxt)
    else $error("write command not taken");

  a_read_answer: assert property (seq_read_cmd |=> seq_read_reply ##0
    ulpi_data_out == ($past(fc_reg) & FC_READ_MASK) ##1 !ulpi_dir)
    else $error("read reply wrong");

  a_plain_write: assert property (commit && wr_kind == WR_PLAIN && !low_power_exit |=>
    fc_reg == ($past(wdata_reg) & FC_WRITE_MASK))
    else $error("plain write wrong");

  a_unmapped_write: assert property (
    state_reg == ST_WR_STP && ulpi_stp && !addr_mapped && !low_power_exit |=> $stable(fc_reg))
    else $error("unmapped write changed register");

  a_style_nondrive: assert property (
    transmit_style == STYLE_NON_DRIVING |=> !tx_drive_en && bitstuff_nrzi_en)
    else $error("non-driving style wrong");

  a_style_nostuff: assert property (
    transmit_style == STYLE_NO_STUFF_NRZI |=> !bitstuff_nrzi_en && tx_drive_en)
    else $error("stuffing style wrong");

  a_ls_select: assert property (
    fc_reg[FC_LOW_POWER_N_BIT] && speed_select == SPEED_LS |=> ls_xcvr_en && !hs_xcvr_en)
    else $error("LS select wrong");

  a_term_pullup: assert property (
    termination_select && !plus_line_pulldown && !minus_line_pulldown &&
    speed_select != SPEED_LS |=> pullup_dp_en && !pullup_dm_en)
    else $error("pull-up select wrong");

  a_rxcmd_fields: assert property (ulpi_data_oe && $past(state_reg) == ST_XR_TURN |->
    ulpi_data_out[RXCMD_LINE_LSB +: 2] == $past(line_state) &&
    ulpi_data_out[RXCMD_VBUS_LSB +: 2] == $past(vbus_state))
    else $error("RX command content wrong");
endmodule
`default_nettype wire

//--- ulpi_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module ulpi_link_model (
  input wire logic mclk,
  input wire logic dir,
  input wire logic nxt,
  input wire logic [7:0] bus,
  output logic [7:0] link_d,
  output logic link_oe,
  output logic stp,
  output int errs
);
  localparam logic [1:0] CMD_W = 2'h2;
  localparam logic [1:0] CMD_R = 2'h3;

  // Let go of the bus as soon as the transceiver takes it, or both ends would fight
  assign link_oe = !dir;

  initial begin
    link_d = 8'h00;
    stp = 1'b0;
    errs = 0;
  end

  function automatic logic pick(input int sel);
    case (sel)
      0: pick = nxt;
      1: pick = dir;
      default: pick = !dir;
    endcase
  endfunction

  // Sampled at the edge, so a late flag is never mistaken for an early one
  task automatic wait_on(input int sel);
    int n;
    n = 0;
    @(posedge mclk);
    while (pick(sel) !== 1'b1) begin
      n++;
      if (n > 40) begin
        errs++;
        return;
      end
      @(posedge mclk);
    end
  endtask

  task automatic reg_write(input logic [5:0] addr, input logic [7:0] data);
    link_d <= {CMD_W, addr};
    wait_on(0);
    link_d <= data;
    wait_on(0);
    link_d <= 8'h00;
    stp <= 1'b1;
    @(posedge mclk);
    stp <= 1'b0;
  endtask

  task automatic reg_read(input logic [5:0] addr, output logic [7:0] data);
    link_d <= {CMD_R, addr};
    wait_on(0);
    link_d <= 8'h00;
    wait_on(1);
    @(posedge mclk);
    data = bus;
    wait_on(2);
  endtask

endmodule
`default_nettype wire

//--- ulpi_func_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
module ulpi_func_ctrl_test
  import ulpi_fc_pkg::*;
;
  // Short core reset keeps the run brief; the hold count and the sampling window follow NRST
  localparam int NRST = 2;
  int n_fail = 0;
  int n_compared = 0;
  int seed = 32'hf2398e1e;
  int mreg = 8'h41;
  int lerr;
  int rises;
  int hold;
  logic pdir;
  logic [7:0] rx = 8'h00;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic low_power_exit = 1'b0;
  logic [1:0] line_state = 2'h0;
  logic [1:0] vbus_state = 2'h0;
  logic dp_pd = 1'b0;
  logic dm_pd = 1'b0;
  logic [7:0] last_bus = 8'h00;
  logic [7:0] link_d;
  logic [7:0] data_out;
  logic oe, dir, nxt, stp, link_oe, low_power_n, term, core_reset;
  logic [1:0] speed;
  logic [1:0] style;
  wire logic [CTL_W-1:0] got_ctl;
  wire logic [7:0] bus;

  always #50 mclk = ~mclk;
  // Nobody driving: show a changing value rather than a stale one
  assign bus = oe ? data_out : (link_oe ? link_d : ~last_bus);
  always @(posedge mclk) last_bus <= bus;

  ulpi_func_ctrl #(.CORE_RESET_CYCLES(NRST)) dut (
    .mclk(mclk), .arst_n(arst_n), .ulpi_data_in(bus), .ulpi_data_out(data_out),
    .ulpi_data_oe(oe), .ulpi_dir(dir), .ulpi_nxt(nxt), .ulpi_stp(stp),
    .low_power_exit(low_power_exit), .line_state(line_state), .vbus_state(vbus_state),
    .plus_line_pulldown(dp_pd), .minus_line_pulldown(dm_pd), .low_power_n(low_power_n),
    .speed_select(speed), .transmit_style(style), .termination_select(term),
    .core_reset(core_reset), .core_power_en(got_ctl[CTL_CORE_POWER]),
    .hs_xcvr_en(got_ctl[CTL_HS_XCVR]), .fs_xcvr_en(got_ctl[CTL_FS_XCVR]),
    .ls_xcvr_en(got_ctl[CTL_LS_XCVR]), .fs_preamble_en(got_ctl[CTL_FS_PREAMBLE]),
    .tx_drive_en(got_ctl[CTL_TX_DRIVE]), .bitstuff_nrzi_en(got_ctl[CTL_BITSTUFF_NRZI]),
    .style_reserved(got_ctl[CTL_STYLE_RSVD]), .pullup_dp_en(got_ctl[CTL_PULLUP_DP]),
    .pullup_dm_en(got_ctl[CTL_PULLUP_DM]), .hs_term_en(got_ctl[CTL_HS_TERM])
  );

  ulpi_link_model link (
    .mclk(mclk), .dir(dir), .nxt(nxt), .bus(bus), .link_d(link_d),
    .link_oe(link_oe), .stp(stp), .errs(lerr)
  );

  task automatic wrap_up();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [CTL_W-1:0] want_ctl(input int fc, input logic pd);
    int spd;
    int sty;
    logic tm;
    logic aw;
    spd = fc % 4;
    sty = (fc / 8) % 4;
    tm = fc[2];
    aw = fc[6];
    want_ctl = '0;
    want_ctl[CTL_CORE_POWER] = aw;
    want_ctl[CTL_HS_XCVR] = aw && spd == 0;
    want_ctl[CTL_FS_XCVR] = aw && (spd == 1 || spd == 3);
    want_ctl[CTL_LS_XCVR] = aw && spd == 2;
    want_ctl[CTL_FS_PREAMBLE] = spd == 3;
    // Reserved style drives as normal
    want_ctl[CTL_TX_DRIVE] = sty != 1;
    want_ctl[CTL_BITSTUFF_NRZI] = sty != 2;
    want_ctl[CTL_STYLE_RSVD] = sty == 3;
    want_ctl[CTL_PULLUP_DP] = !pd && tm && spd != 2;
    want_ctl[CTL_PULLUP_DM] = !pd && tm && spd == 2;
    want_ctl[CTL_HS_TERM] = !tm && spd == 0 && sty != 1;
  endfunction

  task automatic link_ok();
    if (lerr != 0) begin
      n_fail++;
      wrap_up();
    end
  endtask

  task automatic wr(input int a, input int v);
    link.reg_write(6'(a), 8'(v));
    case (a)
      4: mreg = v & 8'h7f;
      5: mreg = mreg | (v & 8'h7f);
      6: mreg = mreg & ~v;
      default: mreg = mreg;
    endcase
    link_ok();
  endtask

  task automatic rd(input int a);
    logic [7:0] got;
    link.reg_read(6'(a), got);
    link_ok();
    chk("read", (a >= 4 && a <= 6) ? 16'(mreg & 8'h5f) : 16'h0000, {8'h00, got});
  endtask

  task automatic check_ports();
    chk("decode", 16'(want_ctl(mreg, dp_pd | dm_pd)), 16'(got_ctl));
    chk("fields", 16'(mreg & 8'h5f), {9'h000, low_power_n, 1'b0, style, term, speed});
  endtask

  initial begin
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    rd(4);
    check_ports();
    for (int i = 0; i < 40; i++) begin
      dp_pd <= 1'($random(seed));
      dm_pd <= 1'($random(seed));
      // First sweep visits every style and speed code; bit 7 junk must be dropped
      if (i < 16) begin
        wr(4, ($random(seed) & 8'hc4) | ((i / 4) * 8) | (i % 4));
      end else begin
        wr(4 + i % 3, $random(seed) & ((i % 3 == 2) ? 8'hff : 8'hdf));
      end
      rd(4 + i % 3);
      check_ports();
    end
    wr(4, 8'h41);
    wr(6, 8'h40);
    rd(4);
    check_ports();
    low_power_exit <= 1'b1;
    @(posedge mclk);
    low_power_exit <= 1'b0;
    repeat (3) @(posedge mclk);
    mreg = mreg | 8'h40;
    check_ports();
    rd(5);
    // Wake-up held across a clearing write: the hardware set must win
    low_power_exit <= 1'b1;
    wr(6, 8'h40);
    low_power_exit <= 1'b0;
    mreg = mreg | 8'h40;
    rd(4);
    wr(4, 8'h5e);
    line_state <= 2'($random(seed));
    vbus_state <= 2'($random(seed));
    wr(5, 8'h20);
    mreg = mreg & 8'hdf;
    pdir = 1'b0;
    rises = 0;
    hold = 0;
    for (int i = 0; i < NRST + 12; i++) begin
      @(posedge mclk);
      if (dir === 1'b1 && pdir !== 1'b1) rises++;
      pdir = dir;
      if (core_reset === 1'b1) hold++;
      if (oe === 1'b1) rx = data_out;
    end
    chk("hold", 16'(NRST), 16'(hold));
    chk("dir_rises", 16'h0002, 16'(rises));
    chk("rxcmd", {8'h00, 4'h0, vbus_state, line_state}, {8'h00, rx});
    rd(4);
    check_ports();
    wr(7, 8'h5a);
    rd(7);
    rd(6);
    wrap_up();
  end

  initial begin
    #(100000 * 100);
    n_fail++;
    wrap_up();
  end
endmodule
`default_nettype wire
